// ===== bdr_cfg.svh
`ifndef BDR_CFG_SVH
`define BDR_CFG_SVH

// Register byte addresses on the parallel bus.
`define BDR_A_INSTR    16'hff00
`define BDR_A_STATUS   16'hff01
`define BDR_A_SHIFT_HI 16'hff02
`define BDR_A_SHIFT_LO 16'hff03
`define BDR_A_ADDR_HI  16'hff04
`define BDR_A_ADDR_LO  16'hff05
`define BDR_A_CCR      16'hff06

// Status bit positions and reset value.
`define BDR_ST_EN     7
`define BDR_ST_ACT    6
`define BDR_ST_TAG    5
`define BDR_ST_SDV    4
`define BDR_ST_TRC    3
`define BDR_ST_CKS    2
`define BDR_ST_RST    8'h00

// Instruction bit positions and fields.
`define BDR_IR_HF     7
`define BDR_IR_DATA   6
`define BDR_IR_RW     5
`define BDR_IR_BGND   4
`define BDR_IR_WB     3
`define BDR_IR_MAP    2
`define BDR_IR_RST    8'h00
`define BDR_IR_HWMASK 8'hfc
`define BDR_TTG_HI    4
`define BDR_TTG_LO    3
`define BDR_REG_HI    2
`define BDR_REG_LO    0

// Command encodings.
`define BDR_CMD_BGND  8'h90
`define BDR_TTG_GO    2'h1
`define BDR_TTG_TRC   2'h2
`define BDR_TTG_TAG   2'h3
`define BDR_REG_NEXT  3'h2
`define BDR_REG_PC    3'h3
`define BDR_NEXT_STEP 16'h0002

// Cycle counts.
`define BDR_ACT_DLY    3'h4
`define BDR_TAG_DLY    5'h10
`define BDR_IDLE_TICKS 10'h200
`define BDR_CMD_BITS   5'h08
`define BDR_WORD_BITS  5'h10

`endif

// ===== bdr_pkg.sv
`include "bdr_cfg.svh"

package bdr_pkg;
  typedef enum logic [1:0] {
    BDR_SER_CMD  = 2'b01,
    BDR_SER_DATA = 2'b10
  } bdr_ser_e;

  // Number of 16-bit words that follow a command byte.
  function automatic logic [1:0] bdr_words(input logic [7:0] cmd);
    if (!cmd[`BDR_IR_DATA]) begin
      return 2'h0;
    end
    if (cmd[`BDR_IR_HF]) begin
      return 2'h2;
    end
    return 2'h1;
  endfunction
endpackage

// ===== bdr_ser_if.sv
interface bdr_ser_if;
  logic        bit_valid;
  logic        bit_val;
  logic        halt;
  logic        abort;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        word_valid;
  logic [15:0] word;
  logic        busy;

  modport engine (input bit_valid, bit_val, halt, abort,
                  output cmd_valid, cmd_byte, word_valid, word, busy);
  modport core (output bit_valid, bit_val, halt, abort,
                input cmd_valid, cmd_byte, word_valid, word, busy);
endinterface

// ===== bdr_shift.sv
`include "bdr_cfg.svh"

module bdr_shift (
  input wire logic  clk,
  input wire logic  rst_n,
  bdr_ser_if.engine ser
);
  bdr_pkg::bdr_ser_e state_ff;
  bdr_pkg::bdr_ser_e nxt_state;
  logic [4:0]        cnt_ff;
  logic [4:0]        nxt_cnt;
  logic [15:0]       acc_ff;
  logic [15:0]       nxt_acc;
  logic [1:0]        words_ff;
  logic [1:0]        nxt_words;
  logic              cmd_v_ff;
  logic              nxt_cmd_v;
  logic              word_v_ff;
  logic              nxt_word_v;
  logic [15:0]       acc_in;

  assign acc_in = {acc_ff[14:0], ser.bit_val};

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_acc    = acc_ff;
    nxt_words  = words_ff;
    nxt_cmd_v  = 1'b0;
    nxt_word_v = 1'b0;
    if (ser.abort) begin
      nxt_state = bdr_pkg::BDR_SER_CMD;
      nxt_cnt   = 5'h00;
      nxt_words = 2'h0;
    end else if (ser.bit_valid && !ser.halt) begin
      nxt_acc = acc_in;
      nxt_cnt = cnt_ff + 5'h01;
      case (state_ff)
        bdr_pkg::BDR_SER_CMD: begin
          if (nxt_cnt == `BDR_CMD_BITS) begin
            nxt_cmd_v = 1'b1;
            nxt_cnt   = 5'h00;
            nxt_words = bdr_pkg::bdr_words(acc_in[7:0]);
            if (nxt_words != 2'h0) begin
              nxt_state = bdr_pkg::BDR_SER_DATA;
            end
          end
        end
        bdr_pkg::BDR_SER_DATA: begin
          if (nxt_cnt == `BDR_WORD_BITS) begin
            nxt_word_v = 1'b1;
            nxt_cnt    = 5'h00;
            nxt_words  = words_ff - 2'h1;
            if (words_ff == 2'h1) begin
              nxt_state = bdr_pkg::BDR_SER_CMD;
            end
          end
        end
        default: begin
          nxt_state = bdr_pkg::BDR_SER_CMD;
          nxt_cnt   = 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= bdr_pkg::BDR_SER_CMD;
      cnt_ff    <= 5'h00;
      acc_ff    <= 16'h0000;
      words_ff  <= 2'h0;
      cmd_v_ff  <= 1'b0;
      word_v_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      acc_ff    <= nxt_acc;
      words_ff  <= nxt_words;
      cmd_v_ff  <= nxt_cmd_v;
      word_v_ff <= nxt_word_v;
    end
  end

  assign ser.cmd_valid  = cmd_v_ff;
  assign ser.cmd_byte   = acc_ff[7:0];
  assign ser.word_valid = word_v_ff;
  assign ser.word       = acc_ff;
  assign ser.busy       = (state_ff == bdr_pkg::BDR_SER_DATA) || (cnt_ff != 5'h00);

  abort_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    ser.abort |=> (cnt_ff == 5'h00) && (state_ff == bdr_pkg::BDR_SER_CMD) && !cmd_v_ff)
    else $error("shifter did not restart after abort");

  halt_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ser.halt && !ser.abort) |=> $stable(cnt_ff) && !cmd_v_ff && !word_v_ff)
    else $error("shifter moved while halted");
endmodule

// ===== bdr_top.sv
`include "bdr_cfg.svh"

// Overview of operation
// - Enable clear blocks active entry, hardware commands run; mode-strap entry and active-bit status writes bypass it here.
// - Enable resets to zero; firmware sets it.
// - Active set on entry; cleared write lands 4 cycles later.
// - Tagging set by tag-go, cleared on entry, 16-cycle delay.
// - No serial commands processed while tagging active.
// - Shifter-valid shows a completed shift.
// - Trace bit set by single-step command.
// - Clock select: 0 bus clock, 1 E clock.
// - Slower E clock forces E clock.
// - 512 idle debug ticks clear instruction register.
// - Instruction loads serially; parallel bus access too.
// - Hardware instruction bit decode, bits 1:0 zero.
// - Value 90 hex requests active debug entry.
// - Map select picks debug or user high page.
// - Trace/tag/go field: nop, go, trace, tag-go.
// - Register field selects next, PC, D, X, Y, SP.
// - Next access pre-increments X by 2.
// - Shift register is serial data, read/write always.
// - Address register written only by hardware, readable.
// - Entry saves condition codes; holding register read/write.
// - Active writable if H/F zero, clock select if one.
//
module bdr_top (
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        DBG_TICK,
  input  wire logic        E_CLOCK_SLOWER,
  input  wire logic        SPECIAL_SINGLE,
  input  wire logic        SPECIAL_PERIPH,
  input  wire logic        PIN_FALL,
  input  wire logic        PIN_BIT_VALID,
  input  wire logic        PIN_BIT,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  output logic      [7:0]  BUS_RDATA,
  output logic             BUS_HIT,
  input  wire logic        BKPT_ENTER,
  input  wire logic [7:0]  CPU_CCR,
  input  wire logic [15:0] CPU_X,
  input  wire logic        MEM_ACK,
  input  wire logic [15:0] MEM_RDATA,
  output logic             DEBUG_ACTIVE,
  output logic             DEBUG_CLK_SEL,
  output logic             TAG_ENABLE,
  output logic             FW_GO,
  output logic             FW_TRACE,
  output logic             FW_TAG_AND_GO_CMD,
  output logic             FW_REG_STB,
  output logic      [2:0]  FW_REG_SEL,
  output logic      [15:0] NEXT_ADDR,
  output logic             MEM_REQ,
  output logic             MEM_WRITE,
  output logic             MEM_WORD,
  output logic             MEM_MAP_DEBUG,
  output logic      [15:0] MEM_ADDR,
  output logic      [15:0] MEM_WDATA
);
  ////////////////////////////////////////////////////////////////////////////
  logic        en_ff, nxt_en;
  logic        act_ff, nxt_act;
  logic        tag_ff, nxt_tag;
  logic        sdv_ff, nxt_sdv;
  logic        trc_ff, nxt_trc;
  logic        cks_ff, nxt_cks;
  logic        init_ff, nxt_init;
  logic        pend_ff, nxt_pend;
  logic        aval_ff, nxt_aval;
  logic [2:0]  acnt_ff, nxt_acnt;
  logic [4:0]  tcnt_ff, nxt_tcnt;
  logic        ton_ff, nxt_ton;
  logic [7:0]  instr_ff, nxt_instr;
  logic [9:0]  idle_ff, nxt_idle;
  logic        tmo_ff, nxt_tmo;
  logic [15:0] addr_ff, nxt_addr;
  logic [15:0] shift_ff, nxt_shift;
  logic [7:0]  ccr_ff, nxt_ccr;
  logic        widx_ff, nxt_widx;
  logic        mreq_ff, nxt_mreq;
  logic        mwr_ff, nxt_mwr;
  logic        mword_ff, nxt_mword;
  logic        mmap_ff, nxt_mmap;
  logic        go_ff, nxt_go;
  logic        trc1_ff, nxt_trc1;
  logic        tgo_ff, nxt_tgo;
  logic        rstb_ff, nxt_rstb;
  logic [2:0]  rsel_ff, nxt_rsel;
  logic [15:0] next_ff, nxt_next;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        hit_ff, nxt_hit;
  logic        clk_ff, nxt_clk;
  logic        map_on;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [7:0]  cmd;
  logic [1:0]  ttg;
  logic [2:0]  regf;
  logic        hw_bgnd;
  logic        fw_v;
  logic        enter;
  logic        hw_st_wr;
  logic        st_wr;
  logic [7:0]  st_data;
  logic        act_wr;
  logic        cks_wr;
  logic        tag_cmd;
  logic        tmo_now;

  bdr_ser_if ser ();

  bdr_shift u_shift (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .ser   (ser)
  );

  assign ser.bit_valid = PIN_BIT_VALID;
  assign ser.bit_val   = PIN_BIT;
  assign ser.halt      = ton_ff;
  assign ser.abort     = tmo_ff;

  // Register decode for one address of the parallel map.
  function automatic logic bus_at(input logic [15:0] off);
    return map_on && (BUS_ADDR == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The parallel map is only visible while active or in peripheral mode.
  assign map_on  = act_ff || SPECIAL_PERIPH;
  assign cpu_wr  = BUS_WR && map_on;
  assign cpu_rd  = BUS_RD && map_on;
  assign cmd     = ser.cmd_byte;
  assign ttg     = cmd[`BDR_TTG_HI:`BDR_TTG_LO];
  assign regf    = cmd[`BDR_REG_HI:`BDR_REG_LO];
  assign hw_bgnd = ser.cmd_valid && (cmd == `BDR_CMD_BGND) && cmd[`BDR_IR_BGND];
  // Firmware commands run only out of the debug ROM, hence the active term.
  assign fw_v    = ser.cmd_valid && !cmd[`BDR_IR_HF] && act_ff;
  assign enter   = (hw_bgnd || BKPT_ENTER) && en_ff && !act_ff;
  assign tag_cmd = fw_v && (ttg == `BDR_TTG_TAG);
  // A hardware write of either size to the status address with the debug map chosen.
  assign hw_st_wr = ser.word_valid && instr_ff[`BDR_IR_HF] && widx_ff
                    && !instr_ff[`BDR_IR_RW] && instr_ff[`BDR_IR_MAP]
                    && (addr_ff == `BDR_A_STATUS);
  assign st_wr   = (cpu_wr && bus_at(`BDR_A_STATUS)) || hw_st_wr;
  assign st_data = hw_st_wr ? ser.word[7:0] : BUS_WDATA;
  assign act_wr  = st_wr && !instr_ff[`BDR_IR_HF];
  assign cks_wr  = st_wr && instr_ff[`BDR_IR_HF];
  assign tmo_now = !PIN_FALL && DBG_TICK && (idle_ff == (`BDR_IDLE_TICKS - 10'h001));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_en   = en_ff;
    nxt_act  = act_ff;
    nxt_tag  = tag_ff;
    nxt_sdv  = sdv_ff;
    nxt_trc  = trc_ff;
    nxt_cks  = cks_ff;
    nxt_init = 1'b1;
    nxt_pend = pend_ff;
    nxt_aval = aval_ff;
    nxt_acnt = acnt_ff;
    nxt_tcnt = tcnt_ff;
    nxt_ton  = ton_ff;
    // Mode straps are caught on the first edge after reset release.
    if (!init_ff && (SPECIAL_SINGLE || SPECIAL_PERIPH)) begin
      nxt_act = 1'b1;
    end
    if (st_wr) begin
      nxt_en  = st_data[`BDR_ST_EN];
      nxt_tag = st_data[`BDR_ST_TAG];
      nxt_sdv = st_data[`BDR_ST_SDV];
      nxt_trc = st_data[`BDR_ST_TRC];
    end
    if (cks_wr) begin
      nxt_cks = st_data[`BDR_ST_CKS];
    end
    // The exit store must not unmap the ROM under the next fetches.
    if (act_wr) begin
      nxt_pend = 1'b1;
      nxt_aval = st_data[`BDR_ST_ACT];
      nxt_acnt = 3'h1;
    end else if (pend_ff) begin
      nxt_acnt = acnt_ff + 3'h1;
      if (acnt_ff == (`BDR_ACT_DLY - 3'h1)) begin
        nxt_act  = aval_ff;
        nxt_pend = 1'b0;
      end
    end
    if (ser.bit_valid && !ton_ff) begin
      nxt_sdv = 1'b0;
    end
    if (ser.word_valid || MEM_ACK) begin
      nxt_sdv = 1'b1;
    end
    if (fw_v && (ttg == `BDR_TTG_TRC)) begin
      nxt_trc = 1'b1;
    end
    if (tag_cmd) begin
      nxt_tag = 1'b1;
    end
    if (tag_cmd || st_wr) begin
      nxt_tcnt = 5'h01;
    end else if (tcnt_ff != 5'h00) begin
      nxt_tcnt = tcnt_ff + 5'h01;
      if (tcnt_ff == (`BDR_TAG_DLY - 5'h01)) begin
        nxt_ton  = tag_ff;
        nxt_tcnt = 5'h00;
      end
    end
    if (!tag_ff) begin
      nxt_ton = 1'b0;
    end
    if (enter) begin
      nxt_act  = 1'b1;
      nxt_tag  = 1'b0;
      nxt_ton  = 1'b0;
      nxt_tcnt = 5'h00;
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      en_ff   <= 1'b0;
      act_ff  <= 1'b0;
      tag_ff  <= 1'b0;
      sdv_ff  <= 1'b0;
      trc_ff  <= 1'b0;
      cks_ff  <= 1'b0;
      init_ff <= 1'b0;
      pend_ff <= 1'b0;
      aval_ff <= 1'b0;
      acnt_ff <= 3'h0;
      tcnt_ff <= 5'h00;
      ton_ff  <= 1'b0;
    end else begin
      en_ff   <= nxt_en;
      act_ff  <= nxt_act;
      tag_ff  <= nxt_tag;
      sdv_ff  <= nxt_sdv;
      trc_ff  <= nxt_trc;
      cks_ff  <= nxt_cks;
      init_ff <= nxt_init;
      pend_ff <= nxt_pend;
      aval_ff <= nxt_aval;
      acnt_ff <= nxt_acnt;
      tcnt_ff <= nxt_tcnt;
      ton_ff  <= nxt_ton;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_instr = instr_ff;
    nxt_idle  = idle_ff;
    nxt_tmo   = 1'b0;
    nxt_addr  = addr_ff;
    nxt_shift = shift_ff;
    nxt_ccr   = ccr_ff;
    nxt_widx  = widx_ff;
    nxt_mreq  = 1'b0;
    nxt_mwr   = mwr_ff;
    nxt_mword = mword_ff;
    nxt_mmap  = mmap_ff;
    nxt_go    = 1'b0;
    nxt_trc1  = 1'b0;
    nxt_tgo   = 1'b0;
    nxt_rstb  = 1'b0;
    nxt_rsel  = rsel_ff;
    nxt_next  = next_ff;
    nxt_rdata = 8'h00;
    nxt_hit   = 1'b0;
    nxt_clk   = cks_ff || E_CLOCK_SLOWER;
    if (PIN_FALL) begin
      nxt_idle = 10'h000;
    end else if (DBG_TICK) begin
      nxt_idle = tmo_now ? 10'h000 : idle_ff + 10'h001;
    end
    if (ser.cmd_valid) begin
      nxt_instr = cmd;
      nxt_widx  = 1'b0;
    end else if (cpu_wr && bus_at(`BDR_A_INSTR)) begin
      nxt_instr = BUS_WDATA;
    end
    if (tmo_now) begin
      nxt_instr = `BDR_IR_RST;
      nxt_tmo   = 1'b1;
    end
    if (fw_v) begin
      nxt_go   = (ttg == `BDR_TTG_GO);
      nxt_trc1 = (ttg == `BDR_TTG_TRC);
      nxt_tgo  = (ttg == `BDR_TTG_TAG);
      nxt_rsel = regf;
      nxt_rstb = (regf >= `BDR_REG_NEXT);
      if (regf == `BDR_REG_NEXT) begin
        nxt_next = CPU_X + `BDR_NEXT_STEP;
      end
    end
    if (ser.word_valid) begin
      if (!instr_ff[`BDR_IR_HF]) begin
        nxt_shift = ser.word;
      end else if (!widx_ff) begin
        nxt_addr = ser.word;
        nxt_widx = 1'b1;
        if (instr_ff[`BDR_IR_RW]) begin
          nxt_mreq = 1'b1;
          nxt_mwr  = 1'b0;
        end
      end else if (!instr_ff[`BDR_IR_RW]) begin
        nxt_shift = ser.word;
        if (!hw_st_wr) begin
          nxt_mreq = 1'b1;
          nxt_mwr  = 1'b1;
        end
      end
    end
    if (nxt_mreq) begin
      nxt_mword = instr_ff[`BDR_IR_WB];
      nxt_mmap  = instr_ff[`BDR_IR_MAP];
    end
    if (MEM_ACK) begin
      nxt_shift = MEM_RDATA;
    end
    if (cpu_wr && bus_at(`BDR_A_SHIFT_HI)) begin
      nxt_shift[15:8] = BUS_WDATA;
    end
    if (cpu_wr && bus_at(`BDR_A_SHIFT_LO)) begin
      nxt_shift[7:0] = BUS_WDATA;
    end
    if (cpu_wr && bus_at(`BDR_A_CCR)) begin
      nxt_ccr = BUS_WDATA;
    end
    if (enter) begin
      nxt_ccr = CPU_CCR;
    end
    if (cpu_rd) begin
      nxt_hit = 1'b1;
      case (BUS_ADDR)
        `BDR_A_INSTR:    nxt_rdata = instr_ff[`BDR_IR_HF] ? (instr_ff & `BDR_IR_HWMASK)
                                                           : instr_ff;
        `BDR_A_STATUS:   nxt_rdata = {en_ff, act_ff, tag_ff, sdv_ff, trc_ff, cks_ff, 2'h0};
        `BDR_A_SHIFT_HI: nxt_rdata = shift_ff[15:8];
        `BDR_A_SHIFT_LO: nxt_rdata = shift_ff[7:0];
        `BDR_A_ADDR_HI:  nxt_rdata = addr_ff[15:8];
        `BDR_A_ADDR_LO:  nxt_rdata = addr_ff[7:0];
        `BDR_A_CCR:      nxt_rdata = ccr_ff;
        default:         nxt_hit   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      instr_ff <= `BDR_IR_RST;
      idle_ff  <= 10'h000;
      tmo_ff   <= 1'b0;
      addr_ff  <= 16'h0000;
      shift_ff <= 16'h0000;
      ccr_ff   <= 8'h00;
      widx_ff  <= 1'b0;
      mreq_ff  <= 1'b0;
      mwr_ff   <= 1'b0;
      mword_ff <= 1'b0;
      mmap_ff  <= 1'b0;
      go_ff    <= 1'b0;
      trc1_ff  <= 1'b0;
      tgo_ff   <= 1'b0;
      rstb_ff  <= 1'b0;
      rsel_ff  <= 3'h0;
      next_ff  <= 16'h0000;
      rdata_ff <= 8'h00;
      hit_ff   <= 1'b0;
      clk_ff   <= 1'b0;
    end else begin
      instr_ff <= nxt_instr;
      idle_ff  <= nxt_idle;
      tmo_ff   <= nxt_tmo;
      addr_ff  <= nxt_addr;
      shift_ff <= nxt_shift;
      ccr_ff   <= nxt_ccr;
      widx_ff  <= nxt_widx;
      mreq_ff  <= nxt_mreq;
      mwr_ff   <= nxt_mwr;
      mword_ff <= nxt_mword;
      mmap_ff  <= nxt_mmap;
      go_ff    <= nxt_go;
      trc1_ff  <= nxt_trc1;
      tgo_ff   <= nxt_tgo;
      rstb_ff  <= nxt_rstb;
      rsel_ff  <= nxt_rsel;
      next_ff  <= nxt_next;
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
      clk_ff   <= nxt_clk;
    end
  end

  assign BUS_RDATA     = rdata_ff;
  assign BUS_HIT       = hit_ff;
  assign DEBUG_ACTIVE  = act_ff;
  assign DEBUG_CLK_SEL = clk_ff;
  assign TAG_ENABLE    = ton_ff;
  assign FW_GO         = go_ff;
  assign FW_TRACE      = trc1_ff;
  assign FW_TAG_AND_GO_CMD      = tgo_ff;
  assign FW_REG_STB    = rstb_ff;
  assign FW_REG_SEL    = rsel_ff;
  assign NEXT_ADDR     = next_ff;
  assign MEM_REQ       = mreq_ff;
  assign MEM_WRITE     = mwr_ff;
  assign MEM_WORD      = mword_ff;
  assign MEM_MAP_DEBUG = mmap_ff;
  assign MEM_ADDR      = addr_ff;
  assign MEM_WDATA     = shift_ff;

  ////////////////////////////////////////////////////////////////////////////
  enable_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (init_ff && !en_ff && !act_ff && !pend_ff && !act_wr) |=> !act_ff)
    else $error("active mode entered while disabled");

  bgnd_enter_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (hw_bgnd && en_ff && !act_ff) |=> act_ff && !tag_ff && !TAG_ENABLE)
    else $error("background command did not enter active mode");

  act_delay_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (act_wr && !st_data[`BDR_ST_ACT] && act_ff) |=> act_ff [*3] ##1 !act_ff)
    else $error("active clear not exactly four cycles late");

  tag_delay_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (tag_cmd && !enter && !st_wr) |=> !TAG_ENABLE ##15 (TAG_ENABLE || !tag_ff))
    else $error("tagging not active sixteen cycles after set");

  sdv_set_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ser.word_valid |=> sdv_ff)
    else $error("shifter valid not set after completed shift");

  trace_set_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (fw_v && (ttg == `BDR_TTG_TRC)) |=> trc_ff && FW_TRACE)
    else $error("trace bit not set by single step");

  clk_force_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    E_CLOCK_SLOWER |=> DEBUG_CLK_SEL)
    else $error("slow E clock did not force clock select");

  idle_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    tmo_now |=> (instr_ff == `BDR_IR_RST) ##1 (u_shift.cnt_ff == 5'h00))
    else $error("idle timeout did not clear instruction");

  next_inc_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (fw_v && (regf == `BDR_REG_NEXT)) |=> (NEXT_ADDR == $past(CPU_X) + `BDR_NEXT_STEP))
    else $error("next address not X plus two");

  ccr_save_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    enter |=> (ccr_ff == $past(CPU_CCR)))
    else $error("condition codes not saved on entry");

  cks_guard_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (st_wr && !instr_ff[`BDR_IR_HF]) |=> $stable(cks_ff))
    else $error("clock select changed by firmware write");
endmodule

// ===== bdr_host_model.sv
module bdr_host_model (
  input  wire logic clk,
  input  wire logic tag_en,
  output logic      pin_fall,
  output logic      pin_bit_valid,
  output logic      pin_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pin_fall      = 1'b0;
    pin_bit_valid = 1'b0;
    pin_bit       = 1'b1;
  end

  // Bits are withheld while tagging is on, and no clock-select or status next-write is sent.
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      pin_fall      <= 1'b1;
      pin_bit_valid <= ~tag_en;
      pin_bit       <= v[i];
    end
    @(posedge clk);
    pin_fall      <= 1'b0;
    pin_bit_valid <= 1'b0;
    // The released line must not keep showing the last bit.
    pin_bit       <= ~v[0];
  endtask
endmodule

// ===== bdr_top_tb_top.sv
module bdr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, resetn, e_clock_slower, bkpt, pin_fall, pin_bit_valid, pin_bit;
  logic        bus_wr, bus_rd, act, cks, tag, dbg_tick, go;
  logic [15:0] bus_addr, cpu_x, next_addr;
  logic [7:0]  bus_wdata, rdata, d;
  logic [2:0]  reg_sel;
  int          err_total, n_tests;

  bdr_top bdr_top_i (.REF_CLK(ref_clk), .RESETN(resetn), .DBG_TICK(dbg_tick),
    .E_CLOCK_SLOWER(e_clock_slower), .SPECIAL_SINGLE(1'b0), .SPECIAL_PERIPH(1'b1),
    .PIN_FALL(pin_fall), .PIN_BIT_VALID(pin_bit_valid), .PIN_BIT(pin_bit),
    .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
    .BUS_RDATA(rdata), .BUS_HIT(), .BKPT_ENTER(bkpt), .CPU_CCR(8'h5a), .CPU_X(cpu_x),
    .MEM_ACK(1'b0), .MEM_RDATA(16'h0000), .DEBUG_ACTIVE(act), .DEBUG_CLK_SEL(cks),
    .TAG_ENABLE(tag), .FW_GO(go), .FW_TRACE(), .FW_TAG_AND_GO_CMD(), .FW_REG_STB(),
    .FW_REG_SEL(reg_sel), .NEXT_ADDR(next_addr), .MEM_REQ(), .MEM_WRITE(),
    .MEM_WORD(), .MEM_MAP_DEBUG(), .MEM_ADDR(), .MEM_WDATA());

  bdr_host_model bdr_host_model_i (.clk(ref_clk), .tag_en(tag), .pin_fall(pin_fall),
    .pin_bit_valid(pin_bit_valid), .pin_bit(pin_bit));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data stands for one cycle only, so it is taken just after the answering edge.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    #1;
    chk(nm, {8'h00, rdata}, {8'h00, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_exit;
    wr(16'hff01, 8'h00);
    tick(2);
    chk("act_hold", act, 1'b1);
    tick(1);
    chk("act_clear", act, 1'b0);
  endtask

  task automatic t_refuse;
    bdr_host_model_i.send(16'h0090, 8);
    @(posedge ref_clk);
    bkpt <= 1'b1;
    @(posedge ref_clk);
    bkpt <= 1'b0;
    tick(3);
    chk("act_refused", act, 1'b0);
  endtask

  task automatic t_entry;
    wr(16'hff01, 8'h80);
    bdr_host_model_i.send(16'h0090, 8);
    tick(3);
    chk("act_entry", act, 1'b1);
    rd(16'hff06, 8'h5a, "ccr_saved");
    rd(16'hff00, 8'h90, "instr");
    rd(16'hff01, 8'hc0, "status");
  endtask

  task automatic t_next;
    @(posedge ref_clk);
    cpu_x <= 16'h1234;
    bdr_host_model_i.send(16'h0062, 8);
    tick(3);
    chk("next_addr", next_addr, 16'h1236);
    chk("reg_sel", reg_sel, 3'h2);
    bdr_host_model_i.send(16'h0000, 16);
    tick(3);
    rd(16'hff01, 8'hd0, "shift_valid");
  endtask

  task automatic t_e_clock;
    @(posedge ref_clk);
    e_clock_slower <= 1'b1;
    tick(2);
    chk("clk_forced", cks, 1'b1);
    @(posedge ref_clk);
    e_clock_slower <= 1'b0;
    tick(2);
    chk("clk_bus", cks, 1'b0);
  endtask

  task automatic t_tag;
    bdr_host_model_i.send(16'h0018, 8);
    tick(15);
    chk("tag_early", tag, 1'b0);
    tick(1);
    chk("tag_on", tag, 1'b1);
    rd(16'hff00, 8'h18, "instr_fw");
  endtask

  // Go pulses for one cycle; the trace bit then stays set in the status byte.
  task automatic t_fw;
    bdr_host_model_i.send(16'h0008, 8);
    tick(1);
    chk("go_pulse", go, 1'b1);
    bdr_host_model_i.send(16'h0010, 8);
    tick(3);
    rd(16'hff01, 8'hc8, "trace_bit");
  endtask

  // With every cycle a debug tick and no falling edge, 512 ticks clear the instruction.
  task automatic t_idle;
    @(posedge ref_clk);
    dbg_tick <= 1'b1;
    tick(520);
    rd(16'hff00, 8'h00, "instr_idle");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #100us;
    err_total++;
    complete_run();
  end

  initial begin
    {resetn, e_clock_slower, bkpt, bus_wr, bus_rd, dbg_tick} = '0;
    {bus_addr, cpu_x, bus_wdata} = '0;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(2);
    rd(16'hff01, 8'h40, "status_rst");
    t_exit();
    t_refuse();
    t_entry();
    t_next();
    t_fw();
    t_e_clock();
    t_tag();
    t_idle();
    complete_run();
  end
endmodule
